//--- src/avmrc_pkg.sv
// Purpose: Shared constants and types of the matrix route controller
// Assumes: One 10 MHz clock, synchronous active-low reset
// Notes: Register offsets are byte addresses on a plain strobe port
//
// Summary of operation
// - Video selector 0 mutes, 1-4 pick input
// - Audio selector 0 mutes, 1-4 pick input
// - Video selectors act only while gate high
// - Audio selectors act only while gate high
// - Lock request blocks the takeover button
// - Panel may still view routes when locked
// - Lock during local mode returns to system
// - Takeover flag high exactly while local mode
// - Route reports always show applied source
// - Serial commands route, query status or set verbose
// - Serial reports give notices and status
package avmrc_pkg;
    // Selector width and legal range
    localparam int SEL_W = 3;
    localparam logic [2:0] SRC_MUTE = 3'h0;
    localparam logic [2:0] SRC_MAX = 3'h4;
    // Register port
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h4;
    localparam logic [3:0] OFS_INT_STAT = 4'h8;
    localparam logic [3:0] OFS_INT_MASK = 4'hC;
    // Field positions
    localparam int CTRL_VERBOSE_BIT = 0;
    localparam int STAT_VA_LSB = 0;
    localparam int STAT_VB_LSB = 4;
    localparam int STAT_AA_LSB = 8;
    localparam int STAT_AB_LSB = 12;
    localparam int STAT_LOCAL_BIT = 16;
    // Interrupt event bits
    localparam int EV_W = 3;
    localparam int EV_ROUTE = 0;
    localparam int EV_MODE = 1;
    localparam int EV_CMD_ERR = 2;
    // Reset values
    localparam logic CTRL_VERBOSE_RST = 1'b0;
    localparam logic [2:0] INT_MASK_RST = 3'h0;
    // Serial byte layout: [7:6] op/tag, [5] output b, [2:0] source
    localparam logic [1:0] OP_VIDEO = 2'h0;
    localparam logic [1:0] OP_AUDIO = 2'h1;
    localparam logic [1:0] OP_QUERY = 2'h2;
    localparam logic [1:0] OP_VERBOSE = 2'h3;
    localparam int BYTE_OUT_BIT = 5;
    localparam logic [2:0] STATUS_LAST = 3'h4;
    // Report sequencer states
    typedef enum logic [0:0] {RPT_IDLE, RPT_SEND} avmrc_rpt_t;
    // Source value legal check, shared by all selector paths
    function automatic logic avmrc_src_ok(input logic [2:0] s);
        avmrc_src_ok = (s <= SRC_MAX);
    endfunction
    // Build one report byte
    function automatic logic [7:0] avmrc_mk_byte(input logic [1:0] tag,
                                                 input logic outb,
                                                 input logic [2:0] s);
        avmrc_mk_byte = {tag, outb, 2'h0, s};
    endfunction
endpackage

//--- src/avmrc_route_ctrl.sv
// Purpose: Route control of a four-input, two-output A/V matrix
// Assumes: All inputs synchronous to clk_sys; host keeps to one method
// Notes: Outputs a/b are index 0/1 of the internal route arrays
`timescale 1ns/100ps
module avmrc_route_ctrl
    import avmrc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic video_select_gate,
    input wire logic audio_select_gate,
    input wire logic panel_lock_request,
    input wire logic [2:0] video_route_select_a,
    input wire logic [2:0] video_route_select_b,
    input wire logic [2:0] audio_route_select_a,
    input wire logic [2:0] audio_route_select_b,
    input wire logic panel_takeover_press,
    input wire logic panel_route_write,
    input wire logic panel_route_audio,
    input wire logic panel_route_out,
    input wire logic [2:0] panel_route_src,
    output logic [2:0] panel_view_src,
    output logic panel_takeover_flag,
    output logic [2:0] video_route_report_a,
    output logic [2:0] video_route_report_b,
    output logic [2:0] audio_route_report_a,
    output logic [2:0] audio_route_report_b,
    input wire logic serial_cmd_valid,
    input wire logic [7:0] serial_cmd_data,
    output logic serial_report_valid,
    output logic [7:0] serial_report_data,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    output logic irq
);
    // Host-side routes, panel-side routes, applied routes
    logic [2:0] host_v [2];
    logic [2:0] host_a [2];
    logic [2:0] pnl_v [2];
    logic [2:0] pnl_a [2];
    logic [2:0] route_v [2];
    logic [2:0] route_a [2];
    logic local_mode;
    logic next_local;
    logic verbose;
    logic [2:0] int_stat;
    logic [2:0] int_mask;
    logic [2:0] ev;
    logic route_diff;
    logic cmd_err;
    logic start_query;
    logic notice_pend;
    avmrc_rpt_t rpt_state;
    logic [2:0] rpt_idx;
    logic [2:0] sel_v [2];
    logic [2:0] sel_a [2];
    // Decoded serial command fields
    logic [1:0] cmd_op;
    logic cmd_out;
    logic [2:0] cmd_src;

    assign sel_v[0] = video_route_select_a;
    assign sel_v[1] = video_route_select_b;
    assign sel_a[0] = audio_route_select_a;
    assign sel_a[1] = audio_route_select_b;
    assign cmd_op = serial_cmd_data[7:6];
    assign cmd_out = serial_cmd_data[BYTE_OUT_BIT];
    assign cmd_src = serial_cmd_data[2:0];

    // Illegal selector or serial source, flagged as a command error
    always_comb begin
        cmd_err = 1'b0;
        if (serial_cmd_valid && !cmd_op[1] && !avmrc_src_ok(cmd_src)) begin
            cmd_err = 1'b1;
        end
        for (int i = 0; i < 2; i++) begin
            if (video_select_gate && !avmrc_src_ok(sel_v[i])) begin
                cmd_err = 1'b1;
            end
            if (audio_select_gate && !avmrc_src_ok(sel_a[i])) begin
                cmd_err = 1'b1;
            end
        end
    end

    // Host route holding; serial wins over a gated selector that cycle
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            host_v <= '{SRC_MUTE, SRC_MUTE};
            host_a <= '{SRC_MUTE, SRC_MUTE};
        end else begin
            for (int i = 0; i < 2; i++) begin
                // Gate low keeps the old value
                if (video_select_gate && avmrc_src_ok(sel_v[i])) begin
                    host_v[i] <= sel_v[i];
                end
                if (audio_select_gate && avmrc_src_ok(sel_a[i])) begin
                    host_a[i] <= sel_a[i];
                end
            end
            // Serial routing command
            if (serial_cmd_valid && avmrc_src_ok(cmd_src)) begin
                if (cmd_op == OP_VIDEO) begin
                    host_v[cmd_out] <= cmd_src;
                end else if (cmd_op == OP_AUDIO) begin
                    host_a[cmd_out] <= cmd_src;
                end
            end
        end
    end

    // Mode arbitration: lock forces system mode and blocks takeover
    always_comb begin
        next_local = local_mode;
        if (panel_lock_request) begin
            next_local = 1'b0;
        end else if (panel_takeover_press) begin
            next_local = !local_mode;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            local_mode <= 1'b0;
        end else begin
            local_mode <= next_local;
        end
    end

    // Panel routes: seeded from applied routes on entry to local mode
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pnl_v <= '{SRC_MUTE, SRC_MUTE};
            pnl_a <= '{SRC_MUTE, SRC_MUTE};
        end else if (next_local && !local_mode) begin
            pnl_v <= route_v;
            pnl_a <= route_a;
        end else if (local_mode && panel_route_write
                     && avmrc_src_ok(panel_route_src)) begin
            // Panel edits count only in local mode
            if (panel_route_audio) begin
                pnl_a[panel_route_out] <= panel_route_src;
            end else begin
                pnl_v[panel_route_out] <= panel_route_src;
            end
        end
    end

    // Applied routes follow the owner of the current mode
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            route_v <= '{SRC_MUTE, SRC_MUTE};
            route_a <= '{SRC_MUTE, SRC_MUTE};
        end else if (local_mode) begin
            route_v <= pnl_v;
            route_a <= pnl_a;
        end else begin
            route_v <= host_v;
            route_a <= host_a;
        end
    end

    // Reports straight from the applied routes
    assign video_route_report_a = route_v[0];
    assign video_route_report_b = route_v[1];
    assign audio_route_report_a = route_a[0];
    assign audio_route_report_b = route_a[1];
    assign panel_takeover_flag = local_mode;

    // Panel view: shows the applied route in any mode
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            panel_view_src <= SRC_MUTE;
        end else if (panel_route_audio) begin
            panel_view_src <= route_a[panel_route_out];
        end else begin
            panel_view_src <= route_v[panel_route_out];
        end
    end

    // Route change seen in the cycle before the applied routes move
    always_comb begin
        route_diff = 1'b0;
        for (int i = 0; i < 2; i++) begin
            route_diff = route_diff | (local_mode
                ? (pnl_v[i] != route_v[i]) || (pnl_a[i] != route_a[i])
                : (host_v[i] != route_v[i]) || (host_a[i] != route_a[i]));
        end
    end

    assign start_query = serial_cmd_valid && (cmd_op == OP_QUERY);

    // Event vector feeding the sticky status
    assign ev = {cmd_err, (next_local != local_mode), route_diff};

    // Notice pending: a route change under verbose waits for the sender
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            notice_pend <= 1'b0;
        end else if (route_diff && verbose) begin
            notice_pend <= 1'b1;
        end else if (rpt_state == RPT_IDLE) begin
            notice_pend <= 1'b0;
        end
    end

    // Report sequencer: five bytes, routes a/b video, audio, then mode
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rpt_state <= RPT_IDLE;
            rpt_idx <= 3'h0;
        end else begin
            case (rpt_state)
                RPT_IDLE: begin
                    // Query or queued notice starts a full dump
                    if (start_query || notice_pend) begin
                        rpt_state <= RPT_SEND;
                        rpt_idx <= 3'h0;
                    end
                end
                RPT_SEND: begin
                    // Queries during a dump are dropped; dump is current
                    if (rpt_idx == STATUS_LAST) begin
                        rpt_state <= RPT_IDLE;
                    end else begin
                        rpt_idx <= rpt_idx + 3'h1;
                    end
                end
                default: begin
                    rpt_state <= RPT_IDLE;
                end
            endcase
        end
    end

    // Report byte register
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            serial_report_valid <= 1'b0;
            serial_report_data <= 8'h00;
        end else begin
            serial_report_valid <= (rpt_state == RPT_SEND);
            case (rpt_idx)
                3'h0: serial_report_data <=
                    avmrc_mk_byte(OP_VIDEO, 1'b0, route_v[0]);
                3'h1: serial_report_data <=
                    avmrc_mk_byte(OP_VIDEO, 1'b1, route_v[1]);
                3'h2: serial_report_data <=
                    avmrc_mk_byte(OP_AUDIO, 1'b0, route_a[0]);
                3'h3: serial_report_data <=
                    avmrc_mk_byte(OP_AUDIO, 1'b1, route_a[1]);
                default: serial_report_data <=
                    avmrc_mk_byte(OP_QUERY, 1'b0, {2'h0, local_mode});
            endcase
        end
    end

    // Verbose flag: register write or serial command
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            verbose <= CTRL_VERBOSE_RST;
        end else if (serial_cmd_valid && cmd_op == OP_VERBOSE) begin
            verbose <= serial_cmd_data[0];
        end else if (reg_write && reg_addr == OFS_CTRL) begin
            verbose <= reg_wdata[CTRL_VERBOSE_BIT];
        end
    end

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            int_stat <= 3'h0;
        end else if (reg_write && reg_addr == OFS_INT_STAT) begin
            int_stat <= (int_stat & ~reg_wdata[2:0]) | ev;
        end else begin
            int_stat <= int_stat | ev;
        end
    end

    // Interrupt mask
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            int_mask <= INT_MASK_RST;
        end else if (reg_write && reg_addr == OFS_INT_MASK) begin
            int_mask <= reg_wdata[2:0];
        end
    end

    assign irq = |(int_stat & int_mask);

    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_sys) begin
        reg_rdata <= 32'h0000_0000;
        if (resetn && reg_read) begin
            case (reg_addr)
                OFS_CTRL: reg_rdata[CTRL_VERBOSE_BIT] <= verbose;
                OFS_STAT: begin
                    reg_rdata[STAT_VA_LSB +: 3] <= route_v[0];
                    reg_rdata[STAT_VB_LSB +: 3] <= route_v[1];
                    reg_rdata[STAT_AA_LSB +: 3] <= route_a[0];
                    reg_rdata[STAT_AB_LSB +: 3] <= route_a[1];
                    reg_rdata[STAT_LOCAL_BIT] <= local_mode;
                end
                OFS_INT_STAT: reg_rdata[2:0] <= int_stat;
                OFS_INT_MASK: reg_rdata[2:0] <= int_mask;
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // Checks
    chk_lock_exits_local: assert property (@(posedge clk_sys)
        disable iff (!resetn) panel_lock_request |=> !panel_takeover_flag)
        else $error("lock did not leave local mode");
    chk_lock_blocks_press: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (panel_lock_request && !local_mode) |=> !local_mode)
        else $error("takeover accepted while locked");
    chk_press_enters: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (panel_takeover_press && !panel_lock_request && !local_mode)
        |=> panel_takeover_flag)
        else $error("takeover press ignored");
    chk_video_gate_route: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (video_select_gate && !local_mode && !serial_cmd_valid
         && video_route_select_a <= SRC_MAX) ##1 !local_mode
        |=> video_route_report_a == $past(video_route_select_a, 2))
        else $error("gated video selector not applied");
    chk_audio_gate_route: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (audio_select_gate && !local_mode && !serial_cmd_valid
         && audio_route_select_b <= SRC_MAX) ##1 !local_mode
        |=> audio_route_report_b == $past(audio_route_select_b, 2))
        else $error("gated audio selector not applied");
    chk_gate_low_hold: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (!video_select_gate && !serial_cmd_valid && !local_mode) [*3]
        |-> $stable(video_route_report_b))
        else $error("video route moved with gate low");
    chk_src_range: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        video_route_report_a <= SRC_MAX && audio_route_report_a <= SRC_MAX)
        else $error("route outside legal range");
    chk_query_dump: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (start_query && rpt_state == RPT_IDLE)
        |=> ##1 serial_report_valid [*5] ##1 !serial_report_valid)
        else $error("status dump not five bytes");
    chk_serial_route: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (serial_cmd_valid && cmd_op == OP_AUDIO && !cmd_out
         && cmd_src <= SRC_MAX && !audio_select_gate && !local_mode)
        ##1 !local_mode |=> audio_route_report_a == $past(cmd_src, 2))
        else $error("serial audio route not applied");
    chk_irq_level: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (ev[EV_MODE] && int_mask[EV_MODE]) |=> irq)
        else $error("mode event did not raise interrupt");
    cov_local_round: cover property (@(posedge clk_sys)
        disable iff (!resetn) !local_mode ##1 local_mode ##[1:50] !local_mode);
    cov_lock_kick: cover property (@(posedge clk_sys)
        disable iff (!resetn) local_mode && panel_lock_request);
    cov_notice: cover property (@(posedge clk_sys)
        disable iff (!resetn) notice_pend ##[1:10] serial_report_valid);
endmodule // avmrc_route_ctrl

//--- tb/avmrc_host_model.sv
// Purpose: Host control system model for the route controller
// Assumes: Drives only just after rising edges of clk_sys
// Notes: Uses selectors or serial commands, never both at once
`timescale 1ns/100ps
module avmrc_host_model (
    input wire logic clk_sys,
    output logic video_select_gate,
    output logic audio_select_gate,
    output logic panel_lock_request,
    output logic [2:0] video_route_select_a,
    output logic [2:0] video_route_select_b,
    output logic [2:0] audio_route_select_a,
    output logic [2:0] audio_route_select_b,
    output logic serial_cmd_valid,
    output logic [7:0] serial_cmd_data
);
    // Idle host: gates low, all mute, serial quiet
    initial begin
        video_select_gate = 1'b0;
        audio_select_gate = 1'b0;
        panel_lock_request = 1'b0;
        video_route_select_a = 3'h0;
        video_route_select_b = 3'h0;
        audio_route_select_a = 3'h0;
        audio_route_select_b = 3'h0;
        serial_cmd_valid = 1'b0;
        serial_cmd_data = 8'h00;
    end
    // Selector method; serial channel left idle
    task automatic set_sel(input logic gv, input logic ga,
                           input logic [2:0] va, input logic [2:0] vb,
                           input logic [2:0] aa, input logic [2:0] ab);
        @(posedge clk_sys);
        video_select_gate <= gv;
        audio_select_gate <= ga;
        video_route_select_a <= va;
        video_route_select_b <= vb;
        audio_route_select_a <= aa;
        audio_route_select_b <= ab;
    endtask
    // Serial method; gates dropped so selectors cannot fight
    task automatic send_cmd(input logic [7:0] b);
        @(posedge clk_sys);
        video_select_gate <= 1'b0;
        audio_select_gate <= 1'b0;
        serial_cmd_valid <= 1'b1;
        serial_cmd_data <= b;
        @(posedge clk_sys);
        serial_cmd_valid <= 1'b0;
        // Released data shows the inverse, not a stale copy
        serial_cmd_data <= ~b;
    endtask
    // Panel lockout level
    task automatic set_lock(input logic l);
        @(posedge clk_sys);
        panel_lock_request <= l;
    endtask
endmodule // avmrc_host_model

//--- tb/av_matrix_route_control_tb.sv
// Purpose: Self-checking bench of the matrix route controller
// Assumes: Host model drives selectors, lockout and serial input
// Notes: Three-edge waits cover the two-edge route latency
`timescale 1ns/100ps
module av_matrix_route_control_tb;
    import avmrc_pkg::*;
    logic clk_sys, resetn;
    logic video_select_gate, audio_select_gate, panel_lock_request;
    logic [2:0] video_route_select_a, video_route_select_b;
    logic [2:0] audio_route_select_a, audio_route_select_b;
    logic panel_takeover_press, panel_route_write;
    logic panel_route_audio, panel_route_out;
    logic [2:0] panel_route_src, panel_view_src;
    logic panel_takeover_flag;
    logic [2:0] video_route_report_a, video_route_report_b;
    logic [2:0] audio_route_report_a, audio_route_report_b;
    logic serial_cmd_valid, serial_report_valid;
    logic [7:0] serial_cmd_data, serial_report_data;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic reg_write, reg_read, irq;
    logic [11:0] rep; // All four reports, a then b
    logic [2:0] e [4]; // Expected va vb aa ab
    logic [2:0] h0; // Host video a held back during local mode
    logic [7:0] xb [5]; // Expected dump bytes
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;
    assign rep = {video_route_report_a, video_route_report_b,
                  audio_route_report_a, audio_route_report_b};
    avmrc_route_ctrl u_dut (.clk_sys, .resetn, .video_select_gate,
        .audio_select_gate, .panel_lock_request, .video_route_select_a,
        .video_route_select_b, .audio_route_select_a,
        .audio_route_select_b, .panel_takeover_press, .panel_route_write,
        .panel_route_audio, .panel_route_out, .panel_route_src,
        .panel_view_src, .panel_takeover_flag, .video_route_report_a,
        .video_route_report_b, .audio_route_report_a,
        .audio_route_report_b, .serial_cmd_valid, .serial_cmd_data,
        .serial_report_valid, .serial_report_data, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .irq);
    avmrc_host_model u_host (.clk_sys, .video_select_gate,
        .audio_select_gate, .panel_lock_request, .video_route_select_a,
        .video_route_select_b, .audio_route_select_a,
        .audio_route_select_b, .serial_cmd_valid, .serial_cmd_data);
    // 10 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Ceiling well above the few hundred cycles the run needs
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            finish_test();
        end
    end
    function automatic logic [7:0] f_byte(input logic [1:0] t,
                                          input logic o,
                                          input logic [2:0] s);
        return {t, o, 2'h0, s};
    endfunction
    function automatic logic [2:0] f_src(input int lo);
        return 3'($urandom_range(4, lo));
    endfunction
    task automatic chk_v(input logic [31:0] got, input logic [31:0] exp,
                         input string m);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp, input string m);
        chk_v({31'h0, got}, {31'h0, exp}, m);
    endtask
    task automatic chk_r(input string m);
        chk_v({20'h0, rep}, {20'h0, e[0], e[1], e[2], e[3]}, m);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic reg_rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask
    task automatic pulse_panel(input logic wr, input logic pr,
                               input logic au, input logic ou,
                               input logic [2:0] s);
        @(posedge clk_sys);
        panel_route_write <= wr;
        panel_takeover_press <= pr;
        panel_route_audio <= au;
        panel_route_out <= ou;
        panel_route_src <= s;
        @(posedge clk_sys);
        panel_route_write <= 1'b0;
        panel_takeover_press <= 1'b0;
    endtask
    // Five report bytes in order, valid throughout, then quiet
    task automatic dump_chk(input string m);
        int k;
        #1;
        xb[0] = f_byte(OP_VIDEO, 1'b0, e[0]);
        xb[1] = f_byte(OP_VIDEO, 1'b1, e[1]);
        xb[2] = f_byte(OP_AUDIO, 1'b0, e[2]);
        xb[3] = f_byte(OP_AUDIO, 1'b1, e[3]);
        xb[4] = f_byte(OP_QUERY, 1'b0, 3'h0);
        k = 0;
        while (serial_report_valid !== 1'b1 && k < 6) begin
            tick(1);
            k++;
        end
        for (int i = 0; i < 5; i++) begin
            chk_b(serial_report_valid, 1'b1, m);
            chk_v({24'h0, serial_report_data}, {24'h0, xb[i]}, m);
            tick(1);
        end
        chk_b(serial_report_valid, 1'b0, m);
    endtask
    task automatic finish_test();
        $display("Counts: %0d compares, %0d mismatches", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        resetn = 1'b0;
        panel_takeover_press = 1'b0;
        panel_route_write = 1'b0;
        panel_route_audio = 1'b0;
        panel_route_out = 1'b0;
        panel_route_src = 3'h0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        foreach (e[i]) e[i] = 3'h0;
        void'($urandom(32'hBC32));
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        tick(1);
        chk_r("reset routes");
        chk_b(panel_takeover_flag, 1'b0, "reset flag");
        chk_b(irq, 1'b0, "reset irq");
        reg_rd(OFS_CTRL);
        chk_v(rd, 32'h0, "ctrl reset");
        reg_rd(OFS_INT_MASK);
        chk_v(rd, 32'h0, "mask reset");
        reg_rd(4'h2);
        chk_v(rd, 32'h0, "unmapped read");
        $display("Test reset done");
        // Random routes, extremes first
        for (int n = 0; n < 20; n++) begin
            foreach (e[i]) e[i] = (n == 0) ? SRC_MAX :
                                  (n == 1) ? SRC_MUTE : f_src(0);
            u_host.set_sel(1'b1, 1'b1, e[0], e[1], e[2], e[3]);
            tick(3);
            chk_r("routed");
            reg_rd(OFS_STAT);
            chk_v(rd, {17'h0, e[3], 1'b0, e[2], 1'b0, e[1], 1'b0, e[0]},
                  "status word");
        end
        u_host.set_sel(1'b0, 1'b0, f_src(0), f_src(0), f_src(0), f_src(0));
        tick(3);
        chk_r("gate low hold");
        $display("Test routing done");
        // Interrupt raise, mask, clear; out-of-range selector
        reg_wr(OFS_INT_MASK, 32'h1);
        reg_wr(OFS_INT_STAT, 32'h7);
        chk_b(irq, 1'b0, "irq cleared");
        e[0] = (e[0] == SRC_MAX) ? 3'h1 : e[0] + 3'h1;
        u_host.set_sel(1'b1, 1'b1, e[0], e[1], e[2], e[3]);
        tick(3);
        chk_r("route change");
        chk_b(irq, 1'b1, "irq raised");
        reg_wr(OFS_INT_MASK, 32'h0);
        chk_b(irq, 1'b0, "irq masked");
        reg_wr(OFS_INT_MASK, 32'h7);
        chk_b(irq, 1'b1, "irq unmasked");
        reg_wr(OFS_INT_STAT, 32'h1);
        chk_b(irq, 1'b0, "irq w1c");
        u_host.set_sel(1'b1, 1'b1, 3'h5, e[1], e[2], e[3]);
        tick(3);
        chk_r("bad source kept");
        reg_rd(OFS_INT_STAT);
        chk_v(rd & 32'h4, 32'h4, "cmd error bit");
        chk_b(irq, 1'b1, "cmd error irq");
        u_host.set_sel(1'b1, 1'b1, e[0], e[1], e[2], e[3]);
        reg_wr(OFS_INT_MASK, 32'h0);
        reg_wr(OFS_INT_STAT, 32'h7);
        $display("Test interrupt done");
        // Local mode, panel edit, lockout
        pulse_panel(1'b0, 1'b1, 1'b0, 1'b0, 3'h0);
        tick(2);
        chk_b(panel_takeover_flag, 1'b1, "local entered");
        e[1] = f_src(1);
        pulse_panel(1'b1, 1'b0, 1'b0, 1'b1, e[1]);
        tick(3);
        chk_r("panel edit");
        h0 = (e[0] == SRC_MAX) ? 3'h1 : e[0] + 3'h1;
        u_host.set_sel(1'b1, 1'b1, h0, e[1], e[2], e[3]);
        tick(3);
        chk_r("local keeps panel");
        u_host.set_lock(1'b1);
        tick(3);
        e[0] = h0;
        chk_b(panel_takeover_flag, 1'b0, "lock exits");
        chk_r("host applied");
        pulse_panel(1'b0, 1'b1, 1'b0, 1'b0, 3'h0);
        tick(3);
        chk_b(panel_takeover_flag, 1'b0, "locked press");
        pulse_panel(1'b1, 1'b0, 1'b1, 1'b1, f_src(0));
        tick(3);
        chk_r("locked edit");
        chk_v({29'h0, panel_view_src}, {29'h0, e[3]}, "view");
        u_host.set_lock(1'b0);
        u_host.set_sel(1'b0, 1'b0, e[0], e[1], e[2], e[3]);
        $display("Test panel done");
        // Serial routing, query, verbose notice
        e[0] = f_src(0);
        u_host.send_cmd(f_byte(OP_VIDEO, 1'b0, e[0]));
        tick(3);
        chk_r("serial video");
        e[3] = f_src(0);
        u_host.send_cmd(f_byte(OP_AUDIO, 1'b1, e[3]));
        tick(3);
        chk_r("serial audio");
        u_host.send_cmd({OP_QUERY, 6'h00});
        dump_chk("query dump");
        u_host.send_cmd({OP_VERBOSE, 6'h01});
        reg_rd(OFS_CTRL);
        chk_v(rd, 32'h1, "verbose on");
        e[2] = (e[2] == SRC_MAX) ? 3'h0 : e[2] + 3'h1;
        u_host.send_cmd(f_byte(OP_AUDIO, 1'b0, e[2]));
        dump_chk("notice dump");
        $display("Test serial done");
        finish_test();
    end
endmodule // av_matrix_route_control_tb
